// [pkg/aocr_map.svh]
// Offsets, field positions, reset values and clock counts of the output config bank
`ifndef AOCR_MAP_SVH
`define AOCR_MAP_SVH
// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define AOCR_RPC_OFFSET 8'h18
`define AOCR_OWF_OFFSET 8'h1c
`define AOCR_RPC_RESET 8'h00
`define AOCR_OWF_RESET 8'h00
// Writable bits; bit 5 and bits 7:6 stay zero
`define AOCR_RPC_WMASK 8'hdf
`define AOCR_OWF_WMASK 8'h3f
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AOCR_PROTO_LSB 0
`define AOCR_LANE_LSB 2
`define AOCR_RATE_BIT 4
`define AOCR_CSEL_LSB 6
`define AOCR_PATN_LSB 0
`define AOCR_PAREN_BIT 3
`define AOCR_SPAN_LSB 4
// ----------------------------------------------------------------
// Fixed patterns and output clock half periods (cycles minus one)
// ----------------------------------------------------------------
`define AOCR_PATN_ALT1 16'h5555
`define AOCR_PATN_ALT2 16'h3333
`define AOCR_HALF_DIV1 2'h0
`define AOCR_HALF_DIV2 2'h1
`define AOCR_HALF_DIV4 2'h3
`endif

// [pkg/aocr_pkg.sv]
// Types of the output configuration register bank
package aocr_pkg;
  typedef enum logic [1:0] {
    AOCR_PROTO_SPI = 2'b00,
    AOCR_PROTO_BAD1 = 2'b01,
    AOCR_PROTO_BAD2 = 2'b10,
    AOCR_PROTO_SS = 2'b11
  } aocr_proto_e;
  typedef enum logic [1:0] {
    AOCR_CLK_ECHO = 2'b00,
    AOCR_CLK_INT = 2'b01,
    AOCR_CLK_DIV2 = 2'b10,
    AOCR_CLK_DIV4 = 2'b11
  } aocr_clksel_e;
  typedef enum logic [0:0] {
    AOCR_FR_IDLE = 1'b0,
    AOCR_FR_ACTIVE = 1'b1
  } aocr_frame_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } aocr_sync_s;
  typedef struct packed {
    logic [7:0] rpc;
    logic [7:0] owf;
    logic [7:0] act_rpc;
    logic [7:0] act_owf;
    aocr_frame_e frame;
    logic [7:0] rdata;
    logic [19:0] word;
    logic word_valid;
    logic [3:0] lanes;
    logic [1:0] div_cnt;
    logic ss_clk;
    logic upd;
    logic sclk_prev;
    logic cpol;
    logic cpha;
    logic ddr;
  } aocr_top_s;
endpackage

// [design/aocr_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module aocr_pin_sync import aocr_pkg::*; #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);
  aocr_sync_s s;
  aocr_sync_s next_s;

  // Level moves only once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= {IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
endmodule

// [design/aocr_word_fmt.sv]
// Output word builder: pattern select and parity bits
`timescale 1ns/1ps
module aocr_word_fmt import aocr_pkg::*; #(
  parameter int RES_W = 16
) (
  input wire logic [RES_W-1:0] result,
  input wire logic [7:0] fmt,
  output logic [19:0] word
);
  `include "aocr_map.svh"

  if (RES_W != 16) begin : g_bad_width
    $error("aocr_word_fmt serves a 16-bit result only");
  end

  // ----------------------------------------------------------------
  // Upper field, then parity over it
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] upper;
    logic [4:0] span;
    logic part;
    upper = 16'h0000;
    span = 5'h00;
    part = 1'b0;
    case (fmt[`AOCR_PATN_LSB +: 3])
      3'h4: upper = 16'h0000;
      3'h5: upper = 16'hffff;
      3'h6: upper = `AOCR_PATN_ALT1;
      3'h7: upper = `AOCR_PATN_ALT2;
      default: upper = result;
    endcase
    // Span is 4, 8, 12 or 16 MSBs
    span = {1'b0, fmt[`AOCR_SPAN_LSB +: 2], 2'b00} + 5'h04;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < span) begin
        part = part ^ upper[15-i];
      end
    end
    // Bits 1:0 are not defined by the format and read as zero
    word = {upper, 4'h0};
    if (fmt[`AOCR_PAREN_BIT]) begin
      word[3] = ^upper;
      word[2] = part;
    end
  end
endmodule

// [design/aocr_top.sv]
// Output protocol and data word configuration registers with readout control
`timescale 1ns/1ps
// Contract
// - readout protocol register at offset 018h
// - clock select picks echo, internal, /2, /4
// - clock select only counts in source-synchronous
// - rate bit ignored in SPI protocol
// - SDR once per period, DDR both edges
// - lane field selects one, two, four lanes
// - 00b follows input SPI mode, 11b source-sync
// - word format register at offset 01Ch
// - partial parity over 4/8/12/16 MSBs
// - parity disabled forces D[3:2] zero
// - parity enabled fills D[3] and D[2]
// - pattern 0xx passes conversion result
// - pattern 100 zeros, 101 ones
// - pattern 110 is 5555h, 111 3333h
// - format bits 7:6 read zero
// - input mode sets polarity and phase
module aocr_top import aocr_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] input_protocol,
  input wire logic cs_b_pin,
  input wire logic sclk_pin,
  input wire logic [15:0] conv_data,
  input wire logic conv_valid,
  output logic [19:0] out_word,
  output logic out_word_valid,
  output logic [3:0] lane_enable,
  output logic ss_clk,
  output logic lane_update,
  output logic spi_cpol,
  output logic spi_cpha,
  output logic ddr_active
);
  `include "aocr_map.svh"

  if (ADDR_W < 5) begin : g_bad_addr
    $error("aocr_top needs at least five address bits");
  end

  aocr_top_s s;
  aocr_top_s next_s;
  logic cs_sync;
  logic sclk_sync;
  logic [19:0] fmt_word;

  // ----------------------------------------------------------------
  // Pin synchronisers and word builder
  // ----------------------------------------------------------------
  aocr_pin_sync #(.IDLE_LEVEL(1'b1)) u_cs_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin(cs_b_pin),
    .level(cs_sync)
  );

  aocr_pin_sync #(.IDLE_LEVEL(1'b0)) u_sclk_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin(sclk_pin),
    .level(sclk_sync)
  );

  // Word follows the frame-held format, never the shadow copy
  aocr_word_fmt #(.RES_W(16)) u_fmt (
    .result(conv_data),
    .fmt(s.act_owf),
    .word(fmt_word)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic ss_mode;
    logic [1:0] half;
    logic edge_seen;
    logic clk_next;
    ss_mode = 1'b0;
    half = `AOCR_HALF_DIV1;
    edge_seen = 1'b0;
    clk_next = 1'b0;
    next_s = s;
    next_s.upd = 1'b0;
    next_s.word_valid = 1'b0;
    next_s.rdata = 8'h00;

    // Register writes land in the shadow copies
    if (reg_wr) begin
      if (reg_addr == ADDR_W'(`AOCR_RPC_OFFSET)) begin
        next_s.rpc = reg_wdata & `AOCR_RPC_WMASK;
      end else if (reg_addr == ADDR_W'(`AOCR_OWF_OFFSET)) begin
        next_s.owf = reg_wdata & `AOCR_OWF_WMASK;
      end
    end

    // Reads answer one cycle later; unmapped reads give zero
    if (reg_rd) begin
      if (reg_addr == ADDR_W'(`AOCR_RPC_OFFSET)) begin
        next_s.rdata = s.rpc;
      end else if (reg_addr == ADDR_W'(`AOCR_OWF_OFFSET)) begin
        next_s.rdata = s.owf;
      end
    end

    // Settings are copied only between frames, so a frame never sees a
    // half-applied change; a write in the start cycle waits a frame
    case (s.frame)
      AOCR_FR_IDLE: begin
        next_s.act_rpc = s.rpc;
        next_s.act_owf = s.owf;
        next_s.cpol = input_protocol[1];
        next_s.cpha = input_protocol[0];
        if (!cs_sync) begin
          next_s.frame = AOCR_FR_ACTIVE;
        end
      end
      AOCR_FR_ACTIVE: begin
        if (cs_sync) begin
          next_s.frame = AOCR_FR_IDLE;
        end
      end
      default: next_s.frame = AOCR_FR_IDLE;
    endcase

    // Lane enables from the held lane field
    case (s.act_rpc[`AOCR_LANE_LSB +: 2])
      2'b10: next_s.lanes = 4'h3;
      2'b11: next_s.lanes = 4'hf;
      default: next_s.lanes = 4'h1;
    endcase

    // Unsupported codes 01b and 10b fall back to SPI readout
    ss_mode = (s.act_rpc[`AOCR_PROTO_LSB +: 2] == AOCR_PROTO_SS);
    next_s.ddr = ss_mode & s.act_rpc[`AOCR_RATE_BIT];

    // Output clock and update strobe
    if (ss_mode) begin
      case (s.act_rpc[`AOCR_CSEL_LSB +: 2])
        AOCR_CLK_ECHO: begin
          clk_next = sclk_sync;
          edge_seen = (sclk_sync != s.sclk_prev);
          next_s.div_cnt = 2'h0;
        end
        default: begin
          case (s.act_rpc[`AOCR_CSEL_LSB +: 2])
            AOCR_CLK_DIV2: half = `AOCR_HALF_DIV2;
            AOCR_CLK_DIV4: half = `AOCR_HALF_DIV4;
            default: half = `AOCR_HALF_DIV1;
          endcase
          // Internal clock runs only inside a frame and parks low
          clk_next = 1'b0;
          next_s.div_cnt = 2'h0;
          if (s.frame == AOCR_FR_ACTIVE) begin
            clk_next = s.ss_clk;
            if (s.div_cnt == half) begin
              clk_next = ~s.ss_clk;
              edge_seen = 1'b1;
            end else begin
              next_s.div_cnt = s.div_cnt + 2'h1;
            end
          end
        end
      endcase
      next_s.ss_clk = clk_next;
      // SDR updates on the rising edge only, DDR on both
      next_s.upd = (s.frame == AOCR_FR_ACTIVE) && edge_seen
        && (s.act_rpc[`AOCR_RATE_BIT] || clk_next);
    end else begin
      // SPI readout: launch edge is rising when polarity and phase differ
      next_s.ss_clk = 1'b0;
      next_s.div_cnt = 2'h0;
      next_s.upd = (s.frame == AOCR_FR_ACTIVE) && (sclk_sync != s.sclk_prev)
        && (sclk_sync == (s.cpol ^ s.cpha));
    end
    next_s.sclk_prev = sclk_sync;

    // Capture a formatted word per conversion
    if (conv_valid) begin
      next_s.word = fmt_word;
      next_s.word_valid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{rpc: `AOCR_RPC_RESET, owf: `AOCR_OWF_RESET,
             act_rpc: `AOCR_RPC_RESET, act_owf: `AOCR_OWF_RESET,
             frame: AOCR_FR_IDLE, rdata: 8'h00, word: 20'h00000,
             word_valid: 1'b0, lanes: 4'h1, div_cnt: 2'h0, ss_clk: 1'b0,
             upd: 1'b0, sclk_prev: 1'b0, cpol: 1'b0, cpha: 1'b0, ddr: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = s.rdata;
  assign out_word = s.word;
  assign out_word_valid = s.word_valid;
  assign lane_enable = s.lanes;
  assign ss_clk = s.ss_clk;
  assign lane_update = s.upd;
  assign spi_cpol = s.cpol;
  assign spi_cpha = s.cpha;
  assign ddr_active = s.ddr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  logic rd_rpc;
  logic rd_owf;
  logic wr_rpc;
  logic act_ss;
  logic in_frame;
  assign rd_rpc = reg_rd && (reg_addr == ADDR_W'(`AOCR_RPC_OFFSET));
  assign rd_owf = reg_rd && (reg_addr == ADDR_W'(`AOCR_OWF_OFFSET));
  assign wr_rpc = reg_wr && (reg_addr == ADDR_W'(`AOCR_RPC_OFFSET));
  assign act_ss = (s.act_rpc[1:0] == 2'b11);
  assign in_frame = (s.frame == AOCR_FR_ACTIVE);

  property p_rpc_readback;
    wr_rpc ##1 rd_rpc |=> reg_rdata == ($past(reg_wdata, 2) & 8'hdf);
  endproperty
  a_rpc_readback: assert property (p_rpc_readback)
    else $error("readout protocol register readback wrong");

  property p_rpc_bit5;
    rd_rpc |=> !reg_rdata[5];
  endproperty
  a_rpc_bit5: assert property (p_rpc_bit5)
    else $error("reserved bit 5 read as one");

  property p_owf_top;
    rd_owf |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_owf_top: assert property (p_owf_top)
    else $error("format bits 7:6 read nonzero");

  property p_div4;
    (in_frame && act_ss && s.act_rpc[7:6] == 2'b11 && $rose(ss_clk))
      ##1 (in_frame && act_ss)[*4] |-> $past(ss_clk, 3) && $past(ss_clk) && !ss_clk;
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide-by-four output clock half period wrong");

  property p_no_clk_spi;
    !act_ss |=> !ss_clk;
  endproperty
  a_no_clk_spi: assert property (p_no_clk_spi)
    else $error("output clock runs outside source-synchronous mode");

  property p_spi_ddr;
    s.act_rpc[1:0] == 2'b00 |=> !ddr_active;
  endproperty
  a_spi_ddr: assert property (p_spi_ddr)
    else $error("double rate active in SPI readout");

  property p_sdr_once;
    act_ss && !s.act_rpc[4] && lane_update |=> !lane_update;
  endproperty
  a_sdr_once: assert property (p_sdr_once)
    else $error("single rate updated twice in one period");

  property p_ddr_every;
    (in_frame && act_ss && s.act_rpc[7:4] == 4'b0101)[*2] |=> lane_update;
  endproperty
  a_ddr_every: assert property (p_ddr_every)
    else $error("double rate missed an internal clock edge");

  property p_lane_four;
    s.act_rpc[3:2] == 2'b11 |=> lane_enable == 4'hf;
  endproperty
  a_lane_four: assert property (p_lane_four)
    else $error("four-lane setting not applied");

  property p_lane_one;
    !s.act_rpc[3] |=> lane_enable == 4'h1;
  endproperty
  a_lane_one: assert property (p_lane_one)
    else $error("one-lane setting not applied");

  property p_spi_launch;
    !act_ss && lane_update |-> s.sclk_prev == (spi_cpol ^ spi_cpha);
  endproperty
  a_spi_launch: assert property (p_spi_launch)
    else $error("SPI readout updated on the wrong clock edge");

  property p_pass_result;
    conv_valid && !s.act_owf[2] |=> out_word[19:4] == $past(conv_data);
  endproperty
  a_pass_result: assert property (p_pass_result)
    else $error("conversion result not passed to the word");

  property p_patn_ones;
    conv_valid && s.act_owf[2:0] == 3'b101 |=> out_word[19:4] == 16'hffff;
  endproperty
  a_patn_ones: assert property (p_patn_ones)
    else $error("all-ones pattern wrong");

  property p_patn_alt;
    conv_valid && s.act_owf[2:0] == 3'b110 |=> out_word[19:4] == 16'h5555;
  endproperty
  a_patn_alt: assert property (p_patn_alt)
    else $error("alternating pattern wrong");

  property p_par_off;
    conv_valid && !s.act_owf[3] |=> out_word[3:2] == 2'b00;
  endproperty
  a_par_off: assert property (p_par_off)
    else $error("parity bits set while parity disabled");

  property p_par_full;
    conv_valid && s.act_owf[3] |=> out_word[3] == ^out_word[19:4];
  endproperty
  a_par_full: assert property (p_par_full)
    else $error("full parity bit wrong");

  property p_par_span4;
    conv_valid && s.act_owf[5:3] == 3'b001 |=> out_word[2] == ^out_word[19:16];
  endproperty
  a_par_span4: assert property (p_par_span4)
    else $error("partial parity over four bits wrong");

  property p_frame_hold;
    in_frame && $past(in_frame) |-> $stable(s.act_rpc) && $stable(s.act_owf);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("settings changed inside a frame");

  c_ddr_update: cover property (act_ss && ddr_active && lane_update);
  c_spi_update: cover property (!act_ss && lane_update);
  c_pattern: cover property (conv_valid && s.act_owf[2]);
  c_frame: cover property ($rose(in_frame));
endmodule

// [bench/aocr_host_model.sv]
// Host controller model that frames transfers on the select and serial clock pins
`timescale 1ns/1ps
module aocr_host_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic frame_on,
  input wire logic cpol,
  output logic cs_b_pin,
  output logic sclk_pin
);
  logic [2:0] div;
  logic [4:0] cnt;
  // -------------------------------------------------------------
  // Frame driver
  // -------------------------------------------------------------
  // Serial clock parks at the polarity level between frames and toggles
  // 16 times per frame; an even count returns it to idle before select rises
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cs_b_pin <= 1'b1;
      sclk_pin <= 1'b0;
      div <= 3'h0;
      cnt <= 5'h00;
    end else if (!frame_on) begin
      cs_b_pin <= 1'b1;
      sclk_pin <= cpol;
      div <= 3'h0;
      cnt <= 5'h00;
    end else begin
      cs_b_pin <= 1'b0;
      div <= div + 3'h1;
      if (div == 3'h7 && cnt < 5'h10) begin
        sclk_pin <= ~sclk_pin;
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench of the output configuration register bank
`timescale 1ns/1ps
module testbench;
  import aocr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] input_protocol = 2'h0;
  logic cs_b_pin;
  logic sclk_pin;
  logic [15:0] conv_data = 16'h0000;
  logic conv_valid = 1'b0;
  logic [19:0] out_word;
  logic out_word_valid;
  logic [3:0] lane_enable;
  logic ss_clk;
  logic lane_update;
  logic spi_cpol;
  logic spi_cpha;
  logic ddr_active;
  logic frame_on = 1'b0;
  logic cnt_en = 1'b0;
  logic ss_q = 1'b0;
  logic sclk_q = 1'b0;
  logic [15:0] lfsr = 16'hc925;
  int failures = 0;
  int comparisons = 0;
  int n_rise;
  int n_upd;
  int n_launch;

  always #2.5 clk_sys = ~clk_sys;

  aocr_top DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_protocol(input_protocol), .cs_b_pin(cs_b_pin), .sclk_pin(sclk_pin),
    .conv_data(conv_data), .conv_valid(conv_valid), .out_word(out_word),
    .out_word_valid(out_word_valid), .lane_enable(lane_enable), .ss_clk(ss_clk),
    .lane_update(lane_update), .spi_cpol(spi_cpol), .spi_cpha(spi_cpha),
    .ddr_active(ddr_active)
  );

  aocr_host_model host (
    .clk_sys(clk_sys), .rst_b(rst_b), .frame_on(frame_on), .cpol(input_protocol[1]),
    .cs_b_pin(cs_b_pin), .sclk_pin(sclk_pin)
  );

  // -------------------------------------------------------------
  // Edge counters for the output clock, shift pulses and pin launch edges
  // -------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (cnt_en) begin
      if (ss_clk === 1'b1 && ss_q === 1'b0) n_rise++;
      if (lane_update === 1'b1) n_upd++;
      if (sclk_pin != sclk_q && sclk_pin == (input_protocol[1] ^ input_protocol[0])) n_launch++;
    end
    ss_q <= ss_clk;
    sclk_q <= sclk_pin;
  end

  // -------------------------------------------------------------
  // Helpers: random source, expected word, compares, bus cycles
  // -------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [19:0] word_exp(input logic [15:0] r, input logic [7:0] f);
    logic [15:0] u;
    logic p;
    u = f[2] ? (f[1] ? (f[0] ? 16'h3333 : 16'h5555) : {16{f[0]}}) : r;
    p = ^(u >> (12 - 4 * f[5:4]));
    return f[3] ? {u, ^u, p, 2'b00} : {u, 4'h0};
  endfunction

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp20(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_near(input string what, input int exp, input int got);
    comparisons++;
    if (got < exp - 1 || got > exp + 1) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp8("reg_rdata", exp, reg_rdata);
  endtask

  // Count edges over one window of a source-synchronous frame
  task automatic ss_frame(input logic [1:0] sel, input logic rate);
    int half;
    half = 1 << (sel - 1);
    wr(8'h18, {sel, 1'b0, rate, 4'b0011});
    wait_cyc(4);
    frame_on <= 1'b1;
    wait_cyc(12);
    cmp8("ddr_active", {7'h0, rate}, {7'h0, ddr_active});
    n_rise = 0;
    n_upd = 0;
    cnt_en <= 1'b1;
    wait_cyc(48);
    cnt_en <= 1'b0;
    cmp_near("ss_clk rises", 24 / half, n_rise);
    cmp_near("lane_update", (rate ? 48 : 24) / half, n_upd);
    frame_on <= 1'b0;
    wait_cyc(10);
    cmp8("ss_clk idle", 8'h00, {7'h0, ss_clk});
  endtask

  initial begin
    #200000;
    failures++;
    end_sim();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [15:0] r;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_cyc(6);
    rd(8'h18, 8'h00);
    rd(8'h1c, 8'h00);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'hdf);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'h3f);
    wr(8'h14, 8'h5a);
    rd(8'h14, 8'h00);
    rd(8'h1c, 8'h3f);
    // Write then read with no gap; read data stand one cycle only
    @(posedge clk_sys);
    reg_addr <= 8'h18;
    reg_wdata <= 8'h5f;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp8("reg_rdata back to back", 8'h5f, reg_rdata);
    @(posedge clk_sys);
    #1;
    cmp8("reg_rdata idle", 8'h00, reg_rdata);
    // Random register traffic; protocol kept to the supported codes
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      d = (lfsr[7:0] & 8'hdc) | {6'h0, {2{lfsr[0]}}};
      wr(8'h18, d);
      rd(8'h18, d);
      wr(8'h1c, lfsr[15:8]);
      rd(8'h1c, lfsr[15:8] & 8'h3f);
    end
    // Lane width, rate bit under both protocols
    for (int i = 0; i < 8; i++) begin
      wr(8'h18, {3'b000, 1'b1, i[1:0], {2{i[2]}}});
      wait_cyc(4);
      cmp8("lane_enable", {4'h0, i[1] ? (i[0] ? 4'hf : 4'h3) : 4'h1}, {4'h0, lane_enable});
      cmp8("ddr_active", {7'h0, i[2]}, {7'h0, ddr_active});
    end
    // Output word for every format setting
    for (int f = 0; f < 64; f++) begin
      wr(8'h1c, f[7:0]);
      repeat (3) @(posedge clk_sys);
      lfsr = lfsr_next(lfsr);
      r = (f == 0) ? 16'hffff : lfsr;
      conv_data <= r;
      conv_valid <= 1'b1;
      @(posedge clk_sys);
      conv_valid <= 1'b0;
      #1;
      cmp8("out_word_valid", 8'h01, {7'h0, out_word_valid});
      cmp20("out_word", word_exp(r, f[7:0]), out_word);
    end
    // Source-synchronous clock select and rate
    for (int s = 1; s < 4; s++) begin
      ss_frame(s[1:0], 1'b0);
      ss_frame(s[1:0], 1'b1);
    end
    // A change written during a frame waits for the next frame
    wr(8'h18, 8'h4f);
    wait_cyc(4);
    frame_on <= 1'b1;
    wait_cyc(10);
    wr(8'h18, 8'h43);
    wait_cyc(6);
    cmp8("lane_enable frozen", 8'h0f, {4'h0, lane_enable});
    frame_on <= 1'b0;
    wait_cyc(10);
    cmp8("lane_enable next", 8'h01, {4'h0, lane_enable});
    // SPI readout in every input mode; clock select and rate bit ignored.
    // The last pass runs source-synchronous with the echoed serial clock.
    for (int m = 0; m < 5; m++) begin
      wr(8'h18, (m == 4) ? 8'h03 : 8'hd0);
      input_protocol <= m[1:0];
      wait_cyc(6);
      cmp8("spi mode", {6'h0, m[1:0]}, {6'h0, spi_cpol, spi_cpha});
      n_rise = 0;
      n_upd = 0;
      n_launch = 0;
      cnt_en <= 1'b1;
      frame_on <= 1'b1;
      wait_cyc(150);
      frame_on <= 1'b0;
      wait_cyc(10);
      cnt_en <= 1'b0;
      cmp_near("spi launch", 8, n_launch);
      cmp_near("spi lane_update", n_launch, n_upd);
      cmp_near("ss_clk in spi", (m == 4) ? 8 : 0, n_rise);
    end
    end_sim();
  end
endmodule
